// ===== logic/ddrsb_pkg.sv
package ddrsb_pkg;
    // data group layout: one strobe per byte, two bytes on the bus
    localparam int DQ_W = 16;
    localparam int GRP_N = 2;
    localparam int BYTE_W = 8;
    localparam int COL_W = 10;
    localparam int PAIR_W = 2 * DQ_W;

    // input synchroniser depth (pin to stable level)
    localparam int SYNC_DEPTH = 3;

    // burst length codes on the burst_len input
    localparam logic [1:0] BL_CODE_2 = 2'h1;
    localparam logic [1:0] BL_CODE_4 = 2'h2;
    localparam logic [1:0] BL_CODE_8 = 2'h3;

    // command codes as {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_TERM = 4'h6;
    localparam logic CS_IDLE = 1'h1;

    // reset values of pin drivers
    localparam logic [DQ_W-1:0] DQ_RST = 16'h0000;
    localparam logic [GRP_N-1:0] DQS_RST = 2'h0;
    localparam logic [GRP_N-1:0] DQS_HIGH = 2'h3;
    localparam logic [2:0] PAIRS_RST = 3'h0;

    // owner of the shared data bus
    typedef enum logic [1:0] {
        DDRSB_BUS_IDLE,
        DDRSB_BUS_READ,
        DDRSB_BUS_WRITE
    } ddrsb_bus_e;
endpackage : ddrsb_pkg

// ===== logic/ddrsb_sync3.sv
`timescale 1ns/1ps
module ddrsb_sync3 import ddrsb_pkg::*; #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;

    // three stages; the first one is read only by the second
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta <= '0;
            ff2 <= '0;
            ff3 <= '0;
        end else begin
            meta <= d;
            ff2 <= meta;
            ff3 <= ff2;
        end
    end

    // a bit changes only once the second and third stages agree
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= (ff2 & ff3) | (q & (ff2 ^ ff3));
        end
    end
endmodule : ddrsb_sync3

// ===== logic/ddrsb_strobe_rx.sv
`timescale 1ns/1ps
module ddrsb_strobe_rx import ddrsb_pkg::*; (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic cap_en,
    input wire logic dqs_in,
    input wire logic [BYTE_W-1:0] dq_in,
    input wire logic dm_in,
    output logic pair_valid,
    output logic [2*BYTE_W-1:0] pair_data,
    output logic [1:0] pair_mask
);
    logic [BYTE_W+1:0] s;
    logic dqs_q;
    logic got_lo;
    logic [BYTE_W-1:0] lo_byte;
    logic lo_mask;
    logic dqs_rise;
    logic dqs_fall;

    // strobe, mask and data share one path so their skew stays matched
    ddrsb_sync3 #(.W(BYTE_W + 2)) u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .d({dqs_in, dm_in, dq_in}),
        .q(s)
    );

    assign dqs_rise = s[BYTE_W+1] & ~dqs_q;
    assign dqs_fall = ~s[BYTE_W+1] & dqs_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dqs_q <= 1'b0;
        end else begin
            dqs_q <= s[BYTE_W+1];
        end
    end

    // strobe edges are the capture clock; ignored outside the window
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            got_lo <= 1'b0;
            lo_byte <= '0;
            lo_mask <= 1'b0;
            pair_valid <= 1'b0;
            pair_data <= '0;
            pair_mask <= 2'h0;
        end else begin
            pair_valid <= 1'b0;
            if (!cap_en) begin
                got_lo <= 1'b0;
            end else if (dqs_rise) begin
                lo_byte <= s[BYTE_W-1:0];
                lo_mask <= s[BYTE_W];
                got_lo <= 1'b1;
            end else if (dqs_fall && got_lo) begin
                pair_data <= {s[BYTE_W-1:0], lo_byte};
                pair_mask <= {s[BYTE_W], lo_mask};
                pair_valid <= 1'b1;
                got_lo <= 1'b0;
            end
        end
    end
endmodule : ddrsb_strobe_rx

// ===== logic/ddrsb_data_path.sv
`timescale 1ns/1ps
module ddrsb_data_path import ddrsb_pkg::*; (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ck,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [COL_W-1:0] col_addr,
    input wire logic [1:0] burst_len,
    input wire logic burst_interleave,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [GRP_N-1:0] dqs_in,
    output logic [GRP_N-1:0] dqs_out,
    output logic [GRP_N-1:0] dqs_oe,
    input wire logic [GRP_N-1:0] dm,
    output logic arr_rd_en,
    output logic [COL_W-1:0] arr_rd_col,
    input wire logic [PAIR_W-1:0] arr_rd_data,
    output logic arr_wr_en,
    output logic [COL_W-1:0] arr_wr_col,
    output logic [PAIR_W-1:0] arr_wr_data,
    output logic [2*GRP_N-1:0] arr_wr_mask,
    output logic rd_busy,
    output logic wr_busy
);
    // pairs in a burst: 1, 2 or 4; unknown codes fall back to one pair
    function automatic logic [2:0] pairs_of(input logic [1:0] code);
        case (code)
            BL_CODE_4: pairs_of = 3'h2;
            BL_CODE_8: pairs_of = 3'h4;
            default: pairs_of = 3'h1;
        endcase
    endfunction : pairs_of

    // column of pair k inside a burst, wrapping in the burst's own block
    function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] base,
            input logic [2:0] k, input logic [2:0] pairs, input logic ilv);
        logic [COL_W-1:0] msk;
        logic [COL_W-1:0] off;
        // block of 2*pairs words, so the wrap mask is 2*pairs-1
        msk = {{(COL_W-4){1'b0}}, pairs - 3'h1, 1'b1};
        off = {{(COL_W-4){1'b0}}, k, 1'b0};
        if (ilv) begin
            col_of = base ^ off;
        end else begin
            col_of = (base & ~msk) | ((base + off) & msk);
        end
    endfunction : col_of

    logic ck_s;
    logic ck_q;
    logic ck_rise;
    logic ck_fall;
    logic [COL_W+3:0] cmd_s;
    logic [3:0] cmd;
    logic [COL_W-1:0] col_s;
    logic is_nop;
    logic is_read;
    logic is_write;
    logic [2:0] burst_pairs;

    // the link clock and command pins come from outside mclk's domain
    ddrsb_sync3 #(.W(1)) u_ck_sync (
        .mclk(mclk),
        .resetn(resetn),
        .d(ck),
        .q(ck_s)
    );

    ddrsb_sync3 #(.W(COL_W + 4)) u_cmd_sync (
        .mclk(mclk),
        .resetn(resetn),
        .d({cs_n, ras_n, cas_n, we_n, col_addr}),
        .q(cmd_s)
    );

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ck_q <= 1'b0;
        end else begin
            ck_q <= ck_s;
        end
    end

    // commands count only on the rise; data moves on rise and fall
    assign ck_rise = ck_s & ~ck_q;
    assign ck_fall = ~ck_s & ck_q;
    assign cmd = cmd_s[COL_W+3:COL_W];
    assign col_s = cmd_s[COL_W-1:0];
    assign is_nop = (cmd == CMD_NOP) || (cmd[3] == CS_IDLE);
    assign is_read = (cmd == CMD_READ);
    assign is_write = (cmd == CMD_WRITE);
    assign burst_pairs = pairs_of(burst_len);

    // read side: fetch, hold and launch of word pairs
    logic [2:0] rd_left;
    logic [2:0] rd_idx;
    logic [COL_W-1:0] rd_base;
    logic [2:0] rd_pairs;
    logic rd_ilv;
    logic rd_fetch_d;
    logic pend_valid;
    logic [PAIR_W-1:0] pend_data;
    logic [DQ_W-1:0] hi_word;
    logic driving;
    logic half_seen;
    ddrsb_bus_e bus_owner;

    // each rise is the controlling slot of the next pair
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_left <= PAIRS_RST;
            rd_idx <= PAIRS_RST;
            rd_base <= '0;
            rd_pairs <= PAIRS_RST;
            rd_ilv <= 1'b0;
            arr_rd_en <= 1'b0;
            arr_rd_col <= '0;
        end else begin
            arr_rd_en <= 1'b0;
            if (ck_rise) begin
                if (is_read) begin
                    arr_rd_en <= 1'b1;
                    arr_rd_col <= col_s;
                    rd_base <= col_s;
                    rd_pairs <= burst_pairs;
                    rd_ilv <= burst_interleave;
                    rd_idx <= 3'h1;
                    rd_left <= burst_pairs - 3'h1;
                end else if (rd_left != PAIRS_RST) begin
                    if (is_nop) begin
                        arr_rd_en <= 1'b1;
                        arr_rd_col <= col_of(rd_base, rd_idx, rd_pairs, rd_ilv);
                        rd_idx <= rd_idx + 3'h1;
                        rd_left <= rd_left - 3'h1;
                    end else begin
                        rd_left <= PAIRS_RST;
                    end
                end
            end
        end
    end

    // the array answers one cycle after the fetch; keep the whole pair
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_fetch_d <= 1'b0;
            pend_valid <= 1'b0;
            pend_data <= '0;
        end else begin
            rd_fetch_d <= arr_rd_en;
            if (rd_fetch_d) begin
                pend_valid <= 1'b1;
                pend_data <= arr_rd_data;
            end else if (ck_rise && pend_valid) begin
                pend_valid <= 1'b0;
            end
        end
    end

    // data and strobe leave from the same flops on the same event
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dq_out <= DQ_RST;
            dq_oe <= 1'b0;
            dqs_out <= DQS_RST;
            dqs_oe <= DQS_RST;
            hi_word <= DQ_RST;
            driving <= 1'b0;
        end else if (ck_rise) begin
            if (pend_valid) begin
                dq_out <= pend_data[DQ_W-1:0];
                hi_word <= pend_data[PAIR_W-1:DQ_W];
                dq_oe <= 1'b1;
                dqs_out <= DQS_HIGH;
                dqs_oe <= DQS_HIGH;
                driving <= 1'b1;
            end else if (driving) begin
                dq_oe <= 1'b0;
                dqs_oe <= DQS_RST;
                driving <= 1'b0;
            end else if (is_read) begin
                dqs_out <= DQS_RST;
                dqs_oe <= DQS_HIGH;
            end
        end else if (ck_fall && driving) begin
            dq_out <= hi_word;
            dqs_out <= DQS_RST;
        end
    end

    // marks that the second word of the current pair went out
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            half_seen <= 1'b0;
        end else if (ck_rise) begin
            half_seen <= 1'b0;
        end else if (ck_fall && driving) begin
            half_seen <= 1'b1;
        end
    end

    // write side: per-group capture and commit
    logic [2:0] wr_left;
    logic [2:0] wr_idx;
    logic [COL_W-1:0] wr_base;
    logic [2:0] wr_pairs;
    logic wr_ilv;
    logic wr_sched;
    logic [COL_W-1:0] wr_sched_col;
    logic [COL_W-1:0] wr_cur_col;
    logic wr_inflight;
    logic cap_en;
    logic [GRP_N-1:0] grp_pv;
    logic [GRP_N-1:0] grp_done;
    logic [GRP_N-1:0] next_grp_done;
    logic [2*BYTE_W-1:0] grp_data [GRP_N];
    logic [1:0] grp_mask [GRP_N];
    logic [2*BYTE_W-1:0] hold_data [GRP_N];
    logic [1:0] hold_mask [GRP_N];
    logic commit;

    // one independent capture unit per strobe and its byte
    genvar g;
    generate
        for (g = 0; g < GRP_N; g++) begin : g_grp
            ddrsb_strobe_rx u_rx (
                .mclk(mclk),
                .resetn(resetn),
                .cap_en(cap_en),
                .dqs_in(dqs_in[g]),
                .dq_in(dq_in[g*BYTE_W +: BYTE_W]),
                .dm_in(dm[g]),
                .pair_valid(grp_pv[g]),
                .pair_data(grp_data[g]),
                .pair_mask(grp_mask[g])
            );

            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    hold_data[g] <= '0;
                    hold_mask[g] <= 2'h0;
                end else if (grp_pv[g]) begin
                    hold_data[g] <= grp_data[g];
                    hold_mask[g] <= grp_mask[g];
                end
            end

            // pair word 0 sits in the low half, word 1 in the high half
            assign arr_wr_data[g*BYTE_W +: BYTE_W] = hold_data[g][BYTE_W-1:0];
            assign arr_wr_data[DQ_W + g*BYTE_W +: BYTE_W] = hold_data[g][2*BYTE_W-1:BYTE_W];
            assign arr_wr_mask[g] = hold_mask[g][0];
            assign arr_wr_mask[GRP_N + g] = hold_mask[g][1];
        end
    endgenerate

    // pair k is scheduled on one rise and its data starts on the next
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_left <= PAIRS_RST;
            wr_idx <= PAIRS_RST;
            wr_base <= '0;
            wr_pairs <= PAIRS_RST;
            wr_ilv <= 1'b0;
            wr_sched <= 1'b0;
            wr_sched_col <= '0;
            wr_cur_col <= '0;
            wr_inflight <= 1'b0;
        end else if (ck_rise) begin
            wr_inflight <= wr_sched;
            if (wr_sched) begin
                wr_cur_col <= wr_sched_col;
            end
            wr_sched <= 1'b0;
            if (is_write) begin
                wr_sched <= 1'b1;
                wr_sched_col <= col_s;
                wr_base <= col_s;
                wr_pairs <= burst_pairs;
                wr_ilv <= burst_interleave;
                wr_idx <= 3'h1;
                wr_left <= burst_pairs - 3'h1;
            end else if (wr_left != PAIRS_RST) begin
                if (is_nop) begin
                    wr_sched <= 1'b1;
                    wr_sched_col <= col_of(wr_base, wr_idx, wr_pairs, wr_ilv);
                    wr_idx <= wr_idx + 3'h1;
                    wr_left <= wr_left - 3'h1;
                end else begin
                    wr_left <= PAIRS_RST;
                end
            end
        end
    end

    // window opens a full clock ahead so the preamble is seen
    assign cap_en = wr_sched | wr_inflight;

    // a group's half stays done until the pair commits; a set wins
    assign commit = &grp_done;
    assign next_grp_done = (grp_done & ~{GRP_N{commit}}) | grp_pv;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            grp_done <= '0;
        end else begin
            grp_done <= next_grp_done;
        end
    end

    // commit after the whole pair is in: array write lands at the end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            arr_wr_en <= 1'b0;
            arr_wr_col <= '0;
        end else begin
            arr_wr_en <= commit;
            if (commit) begin
                arr_wr_col <= wr_cur_col;
            end
        end
    end

    // bus ownership, also shown as busy flags
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bus_owner <= DDRSB_BUS_IDLE;
        end else begin
            case (bus_owner)
                DDRSB_BUS_IDLE: begin
                    if (dqs_oe != DQS_RST) begin
                        bus_owner <= DDRSB_BUS_READ;
                    end else if (cap_en) begin
                        bus_owner <= DDRSB_BUS_WRITE;
                    end
                end
                DDRSB_BUS_READ: begin
                    if (dqs_oe == DQS_RST) begin
                        bus_owner <= DDRSB_BUS_IDLE;
                    end
                end
                DDRSB_BUS_WRITE: begin
                    if (!cap_en && grp_done == '0) begin
                        bus_owner <= DDRSB_BUS_IDLE;
                    end
                end
                default: bus_owner <= DDRSB_BUS_IDLE;
            endcase
        end
    end

    assign rd_busy = (bus_owner == DDRSB_BUS_READ);
    assign wr_busy = (bus_owner == DDRSB_BUS_WRITE);

    // checks on the pin protocol
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_first_pair_fetch: assert property (ck_rise && is_read |=> arr_rd_en)
        else $error("read command did not fetch its first pair");
    a_interrupt_stops: assert property (
        ck_rise && rd_left != 3'h0 && !is_nop && !is_read |=> rd_left == 3'h0 && !arr_rd_en)
        else $error("interrupting command did not end the read burst");
    a_pair_both_slots: assert property ($fell(dq_oe) |-> $past(half_seen))
        else $error("read pair released before its second word");
    a_edge_aligned: assert property ($rose(dq_oe) |-> dqs_out == 2'h3 && dqs_oe == 2'h3)
        else $error("read data and strobe not launched together");
    a_preamble_low: assert property ($rose(dqs_oe[0]) && !dq_oe |-> dqs_out == 2'h0)
        else $error("strobe preamble not low");
    a_postamble_low: assert property ($fell(dqs_oe[0]) |-> $past(dqs_out) == 2'h0)
        else $error("strobe released while high");
    a_fall_second_word: assert property (
        ck_fall && driving |=> dqs_out == 2'h0 && dq_out == $past(hi_word))
        else $error("second word or strobe fall missing");
    a_strobe_with_data: assert property (dq_oe |-> dqs_oe == 2'h3)
        else $error("data driven without strobe");
    a_write_commit: assert property (commit |=> arr_wr_en && grp_done == $past(grp_pv))
        else $error("write pair not committed whole");

    c_read_burst: cover property (ck_rise && is_read && burst_pairs == 3'h4);
    c_read_cut: cover property (ck_rise && rd_left != 3'h0 && cmd == CMD_TERM);
    c_back_to_back: cover property (ck_rise && pend_valid && driving);
    c_write_pair: cover property (arr_wr_en && arr_wr_mask != 4'h0);
endmodule : ddrsb_data_path

// ===== verif/ddrsb_ctrl_model.sv
`timescale 1ns/1ps
module ddrsb_ctrl_model import ddrsb_pkg::*; (
    output logic ck,
    output logic [3:0] cmd,
    output logic [COL_W-1:0] col,
    output logic [DQ_W-1:0] dq,
    output logic [GRP_N-1:0] dqs,
    output logic [GRP_N-1:0] dm
);
    int pend = 0;
    // free-running memory clock, phase unrelated to mclk
    initial begin
        {cmd, col, dq, dqs, dm} = {CMD_NOP, 30'h0000000C};
        ck = 1'b0;
        #7;
        forever #160 ck = ~ck;
    end
    // one write pair: preamble, word0 on rise, word1 on fall, postamble
    task automatic drive_pair(input logic [PAIR_W-1:0] d, input logic [3:0] m);
        pend++;
        // a pair that follows straight on finds the strobe already low
        if (pend == 1) begin
            dqs = DQS_RST;
        end
        #80 dq = d[15:0];
        dm = m[1:0];
        #80 dqs = DQS_HIGH;
        #80 dq = d[31:16];
        dm = m[3:2];
        #80 dqs = DQS_RST;
        // hold low, then invert dq and dqs unless a later pair keeps the bus
        #120 pend--;
        if (pend == 0) begin
            dq = ~dq;
            dqs = ~dqs;
        end
    endtask : drive_pair
    // command for the coming rise, half a cycle of setup
    task automatic slot(input logic [3:0] c, input logic [COL_W-1:0] a, input logic w,
                        input logic [PAIR_W-1:0] d, input logic [3:0] m);
        @(negedge ck);
        cmd = c;
        col = a;
        if (w) begin
            fork
                drive_pair(d, m);
            join_none
        end
    endtask : slot
endmodule : ddrsb_ctrl_model

// ===== verif/tb_ddrsb_data_path.sv
`timescale 1ns/1ps
module tb_ddrsb_data_path import ddrsb_pkg::*;;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] burst_len = BL_CODE_2;
    logic burst_interleave = 1'b0;
    logic ck, cs_n, ras_n, cas_n, we_n, dq_oe, arr_rd_en, arr_wr_en, rd_busy, wr_busy;
    logic [3:0] cmd, arr_wr_mask;
    logic [COL_W-1:0] col_addr, arr_rd_col, arr_wr_col;
    logic [DQ_W-1:0] dq_in, dq_out, m_dq;
    logic [GRP_N-1:0] dqs_in, dqs_out, dqs_oe, m_dqs, dm;
    logic [PAIR_W-1:0] arr_rd_data = 32'h00000000;
    logic [PAIR_W-1:0] arr_wr_data;
    logic [22:0] rq[$];
    logic [45:0] wq[$];
    int err_total = 0;
    int samples_checked = 0;
    int seed = 32'h71ef;
    always #20 mclk = ~mclk;
    // shared pins: whoever enables its driver owns the wire
    assign {cs_n, ras_n, cas_n, we_n} = cmd;
    assign dq_in = dq_oe ? dq_out : m_dq;
    assign dqs_in = (dqs_oe & dqs_out) | (~dqs_oe & m_dqs);
    ddrsb_ctrl_model ctrl (.ck, .cmd, .col(col_addr), .dq(m_dq), .dqs(m_dqs), .dm);
    ddrsb_data_path dut (.mclk, .resetn, .ck, .cs_n, .ras_n, .cas_n, .we_n, .col_addr,
        .burst_len, .burst_interleave, .dq_in, .dq_out, .dq_oe, .dqs_in, .dqs_out, .dqs_oe,
        .dm, .arr_rd_en, .arr_rd_col, .arr_rd_data, .arr_wr_en, .arr_wr_col, .arr_wr_data,
        .arr_wr_mask, .rd_busy, .wr_busy);
    function automatic logic [DQ_W-1:0] pat(input logic [COL_W-1:0] a);
        return {6'h2A, a};
    endfunction : pat
    function automatic logic [COL_W-1:0] pcol(input logic [COL_W-1:0] c, input int k,
                                              input int n, input logic ilv);
        logic [COL_W-1:0] mk;
        mk = COL_W'(n - 1);
        return ilv ? (c ^ COL_W'(2 * k)) : ((c & ~mk) | ((c + COL_W'(2 * k)) & mk));
    endfunction : pcol
    // array answers one pair the cycle after each fetch
    always @(posedge mclk) begin
        if (arr_rd_en === 1'b1) begin
            arr_rd_data <= {pat(arr_rd_col + 10'h001), pat(arr_rd_col)};
        end
    end
    // each ck pin edge falls inside one word, clear of both output changes
    always @(ck) begin
        @(negedge mclk);
        if (dqs_oe !== 2'h0) begin
            rq.push_back({rd_busy, wr_busy, dq_oe, dqs_out, dqs_oe, dq_out});
        end
    end
    // commits to the array, in order
    always @(posedge mclk) begin
        if (arr_wr_en === 1'b1) begin
            wq.push_back({arr_wr_col, arr_wr_mask, arr_wr_data});
        end
    end
    task automatic chk(input string nm, input logic [45:0] e, input logic [45:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic complete_run();
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // one command, nx at rise g, then drain; random columns and order
    task automatic run(input logic wr, input logic [1:0] bl, input int g, input logic [3:0] nx);
        int n, p1, tot, f;
        logic ilv;
        logic [COL_W-1:0] c, c2;
        logic [PAIR_W-1:0] d[16];
        logic [3:0] m[16];
        logic [COL_W-1:0] a[16];
        n = (bl == BL_CODE_8) ? 8 : (bl == BL_CODE_4) ? 4 : 2;
        p1 = (g < n / 2) ? g : n / 2;
        tot = p1 + ((nx == CMD_NOP || nx == CMD_TERM) ? 0 : n / 2);
        ilv = 1'($random(seed));
        c = COL_W'($random(seed)) & 10'h3FE;
        c2 = COL_W'($random(seed)) & 10'h3FE;
        for (int i = 0; i < tot; i++) begin
            a[i] = pcol(i < p1 ? c : c2, i < p1 ? i : i - p1, n, ilv);
            d[i + 1] = wr ? PAIR_W'($random(seed)) : {pat(a[i] + 10'h001), pat(a[i])};
            m[i + 1] = 4'($random(seed));
        end
        @(negedge mclk);
        burst_len = bl;
        burst_interleave = ilv;
        rq.delete();
        wq.delete();
        for (int r = 0; r < tot + 4 || r <= g; r++) begin
            ctrl.slot(r == 0 ? (wr ? CMD_WRITE : CMD_READ) : (r == g ? nx : CMD_NOP),
                      r == g ? c2 : c, wr && r >= 1 && r <= tot, d[r % 16], m[r % 16]);
        end
        if (wr) begin
            chk("commit count", 46'(tot), 46'(wq.size()));
            for (int i = 0; i < tot && i < wq.size(); i++) begin
                chk("commit", {a[i], m[i + 1], d[i + 1]}, wq[i]);
            end
        end else begin
            f = 0;
            while (f < rq.size() && rq[f][20] !== 1'b1) begin
                f++;
            end
            chk("preamble", 46'(5'h03), 46'((f > 0) ? rq[f - 1][20:16] : 5'h1F));
            chk("word count", 46'(2 * tot), 46'(rq.size() - f));
            for (int i = 0; i < 2 * tot && f + i < rq.size(); i++) begin
                chk("read word", {23'h0, 2'h2, 1'b1, (i % 2) ? 2'h0 : 2'h3, 2'h3, (i % 2) ?
                    d[i / 2 + 1][31:16] : d[i / 2 + 1][15:0]}, 46'(rq[f + i]));
            end
        end
    endtask : run
    // reset, then every length, interrupts and back-to-back traffic both ways
    initial begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        resetn = 1'b1;
        repeat (8) @(negedge mclk);
        for (int w = 0; w < 2; w++) begin
            for (int b = 0; b < 4; b++) begin
                run(1'(w), 2'(b), 8, CMD_NOP);
            end
            for (int g = 1; g < 4; g++) begin
                run(1'(w), BL_CODE_8, g, CMD_TERM);
            end
            run(1'(w), BL_CODE_2, 1, w ? CMD_WRITE : CMD_READ);
            run(1'(w), BL_CODE_4, 1, w ? CMD_WRITE : CMD_READ);
        end
        complete_run();
    end
    // hang guard
    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        complete_run();
    end
endmodule : tb_ddrsb_data_path
